// *** src/adc_conversion_control.sv ***
`timescale 1ns/1ps
module adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_data,
    input wire logic comparator_event,
    output logic conv_start,
    output logic [SEL_W-1:0] mux_channel,
    output logic [1:0] ref_select,
    output logic supply_attenuate,
    output logic [RATE_W-1:0] sample_rate_code,
    output logic sensor_supply_switch,
    output logic sensor_ground_switch,
    output logic [1:0] diode_current_enable,
    output logic adc_event
);
    localparam int IW = ADDR_W - 2;

    if (ADDR_W < 7 || ADDR_W > 32) begin : g_addr_check
        $error("ADDR_W must lie between 7 and 32");
    end

    seq_if sq();

    logic [7:0] ain_cfg;
    logic [7:0] conf;
    logic continuous_run;
    logic one_shot;
    logic [SEL_W-1:0] channel_select;
    logic [FLAG_N-1:0] flags;
    logic comparator_enable;
    logic [RESULT_W-1:0] result;
    logic result_unread;

    logic aw_held;
    logic w_held;
    logic [IW-1:0] wr_index;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_do;
    logic wr_lane;
    logic rd_take;
    logic [IW-1:0] rd_index;
    logic rd_hit;
    logic wr_hit;
    logic [31:0] rd_mux;
    ref_sel_t kind;
    logic fmt_signed;
    logic [RES_W-1:0] code;
    logic [FLAG_N-1:0] flag_set;
    logic [FLAG_N-1:0] flag_clr;

    adc_sequencer u_seq (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sq(sq)
    );

    // One-shot is ignored while continuous mode holds the sequencer. [RULE_04]
    assign sq.continuous_run = continuous_run;
    assign sq.one_shot = one_shot;
    assign sq.halt_mode = conf[CONF_HALT_BIT];
    assign sq.result_unread = result_unread;
    assign sq.conv_done = conv_done;
    assign conv_start = sq.conv_start;

    // Write address and data are taken in either order, then applied once.
    assign awready = ~aw_held & ~bvalid;
    assign wready = ~w_held & ~bvalid;
    assign wr_do = aw_held & w_held & ~bvalid;
    assign wr_lane = wr_do & wr_strb[0];
    assign arready = ~rvalid;
    assign rd_take = arvalid & arready;
    assign rd_index = araddr[ADDR_W-1:2];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            wr_index <= '0;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            wr_index <= awaddr[ADDR_W-1:2];
        end else if (wr_do) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end else if (wr_do) begin
            w_held <= 1'b0;
        end
    end

    function automatic logic is_mapped(input logic [IW-1:0] idx);
        return idx == IW'(IDX_FLAGS) || idx == IW'(IDX_AINCFG)
            || idx == IW'(IDX_CONF) || idx == IW'(IDX_CTRL)
            || idx == IW'(IDX_RESULT) || idx == IW'(IDX_CMP);
    endfunction

    assign wr_hit = is_mapped(wr_index);
    assign rd_hit = is_mapped(rd_index);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Input configuration also freezes while a conversion is under way.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ain_cfg <= REG_RESET;
        end else if (wr_lane && wr_index == IW'(IDX_AINCFG) && !sq.busy) begin
            ain_cfg <= wr_data[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            conf <= REG_RESET; // [RULE_16]
        end else if (wr_lane && wr_index == IW'(IDX_CONF) && !sq.busy) begin
            conf <= wr_data[7:0] & CONF_MASK; // [RULE_16] [RULE_22]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_select <= '0;
        end else if (wr_lane && wr_index == IW'(IDX_CTRL) && !sq.busy) begin
            channel_select <= wr_data[SEL_LSB +: SEL_W]; // [RULE_18]
        end
    end

    // The run bits stay writable so that software can always stop a run.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            continuous_run <= 1'b0;
            one_shot <= 1'b0;
        end else if (wr_lane && wr_index == IW'(IDX_CTRL)) begin
            continuous_run <= wr_data[CTRL_CONT_BIT]; // [RULE_02]
            one_shot <= wr_data[CTRL_ONE_BIT];
        end else if (sq.clear_one_shot) begin
            one_shot <= 1'b0; // [RULE_03]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            comparator_enable <= 1'b0;
        end else if (wr_lane && wr_index == IW'(IDX_CMP)) begin
            comparator_enable <= wr_data[CMP_EN_BIT];
        end
    end

    // Set wins over a write-one clear in the same cycle. [RULE_17]
    assign flag_set[FLAG_RDY] = sq.finish;
    assign flag_set[FLAG_CMP] = comparator_event;
    for (genvar i = 0; i < FLAG_N; i++) begin : g_flag
        assign flag_clr[i] = wr_lane && wr_index == IW'(IDX_FLAGS)
            && wr_data[i]; // [RULE_21]
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                flags[i] <= 1'b0;
            end else begin
                flags[i] <= flag_set[i] | (flags[i] & ~flag_clr[i]);
            end
        end
    end

    // Ready is hidden from the event line whenever the comparator runs.
    assign adc_event = (flags[FLAG_RDY] & ~comparator_enable)
        | flags[FLAG_CMP]; // [RULE_21]

    function automatic ref_sel_t decode_ref(input logic [SEL_W-1:0] ch,
                                            input logic [7:0] ain);
        logic [3:0] md;
        logic [1:0] tm;
        ref_sel_t r;
        md = ain[AIN_MD_LSB +: 4];
        tm = ain[AIN_TM_LSB +: 2];
        r = REF_INTERNAL; // [RULE_08] [RULE_12]
        if (ch <= CH_AIN_LAST) begin
            // Diode mode on inputs three and four overrides the mode bit.
            if (md[ch[1:0]] || (ch[1] && tm[ch[0]])) begin // [RULE_05]
                r = REF_INTERNAL; // [RULE_12]
            end else begin
                r = REF_SENSOR; // [RULE_11]
            end
        end else if (ch <= CH_CUR_LAST || ch == CH_CUR_DIAG) begin
            r = REF_CURRENT; // [RULE_06] [RULE_07] [RULE_14]
        end else if (ch == CH_DIAG_RATIO_A || ch == CH_DIAG_RATIO_B) begin
            r = REF_SENSOR; // [RULE_09]
        end
        return r;
    endfunction

    assign kind = decode_ref(channel_select, ain_cfg); // [RULE_10]

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_channel <= '0;
            ref_select <= REF_SENSOR;
            supply_attenuate <= 1'b0;
            sample_rate_code <= '0;
            sensor_supply_switch <= 1'b0;
            sensor_ground_switch <= 1'b0;
            diode_current_enable <= '0;
        end else begin
            mux_channel <= channel_select;
            ref_select <= kind; // [RULE_10]
            supply_attenuate <= (channel_select == CH_SUPPLY); // [RULE_13]
            sample_rate_code <= conf[RATE_LSB +: RATE_W];
            sensor_supply_switch <= ain_cfg[AIN_SP_BIT];
            sensor_ground_switch <= ain_cfg[AIN_SN_BIT];
            diode_current_enable <= ain_cfg[AIN_TM_LSB +: 2];
        end
    end

    // Offset-binary from the converter becomes two's complement by the MSB.
    assign fmt_signed = conf[CONF_SIGN_BIT]
        & (kind != REF_CURRENT); // [RULE_14]
    assign code = fmt_signed ? (conv_data ^ SIGN_FLIP) : conv_data; // [RULE_15]

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= '0;
        end else if (sq.finish) begin
            if (conf[CONF_JUST_BIT]) begin
                result <= {{JUST_PAD{fmt_signed & code[RES_W-1]}}, code};
            end else begin
                result <= {code, {JUST_PAD{1'b0}}}; // [RULE_20]
            end
        end
    end

    // A finishing conversion wins over a read of the old result.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_unread <= 1'b0;
        end else if (sq.finish) begin
            result_unread <= 1'b1;
        end else if (rd_take && rd_index == IW'(IDX_RESULT)) begin
            result_unread <= 1'b0; // [RULE_19]
        end
    end

    always_comb begin
        rd_mux = '0;
        if (rd_index == IW'(IDX_FLAGS)) begin
            rd_mux = 32'(flags); // [RULE_17]
        end else if (rd_index == IW'(IDX_AINCFG)) begin
            rd_mux = 32'(ain_cfg);
        end else if (rd_index == IW'(IDX_CONF)) begin
            rd_mux = 32'(conf);
        end else if (rd_index == IW'(IDX_CTRL)) begin
            rd_mux = 32'({continuous_run, one_shot,
                channel_select}); // [RULE_01]
        end else if (rd_index == IW'(IDX_RESULT)) begin
            rd_mux = 32'(result);
        end else if (rd_index == IW'(IDX_CMP)) begin
            rd_mux = 32'(comparator_enable);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (rd_take) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence conf_write_busy;
        wr_lane && wr_index == IW'(IDX_CONF) && sq.busy;
    endsequence

    conf_block_a: assert property ( // [RULE_22]
        conf_write_busy |=> conf == $past(conf))
        else $error("configuration changed during a conversion");
    chan_block_a: assert property ( // [RULE_18]
        wr_lane && wr_index == IW'(IDX_CTRL) && sq.busy
        |=> channel_select == $past(channel_select))
        else $error("channel select changed during a conversion");
    ctrl_top_a: assert property ( // [RULE_01]
        rd_take && rd_index == IW'(IDX_CTRL) |=> rvalid && !rdata[7])
        else $error("control bit 7 read as one");
    ready_mask_a: assert property ( // [RULE_21]
        sq.finish && comparator_enable && !flags[FLAG_CMP] && !comparator_event
        |=> flags[FLAG_RDY] && !adc_event)
        else $error("ready reached the event line with comparator on");
    one_shot_clear_a: assert property ( // [RULE_03]
        sq.clear_one_shot && !(wr_lane && wr_index == IW'(IDX_CTRL))
        |=> !one_shot)
        else $error("one-shot bit not cleared at completion");
    signed_range_a: assert property ( // [RULE_20]
        sq.finish && fmt_signed && conf[CONF_JUST_BIT]
        |=> result[RESULT_W-1:RES_W-1] == '0
            || result[RESULT_W-1:RES_W-1] == '1)
        else $error("signed result out of range");
endmodule

// *** src/adc_ctrl_pkg.sv ***
// Notes on behaviour
// [RULE_01] Control register bit 7 is unimplemented and always reads as zero.
// [RULE_02] Continuous-run set converts back to back; clear means idle.
// [RULE_03] One-shot starts one conversion; hardware clears it when done.
// [RULE_04] Both run bits set: behave as continuous, ignore the one-shot.
// [RULE_05] Codes 0-3: analog inputs, ratiometric or absolute per config.
// [RULE_06] Codes 4-11: bridge currents, high side then low side, bridges 1-4.
// [RULE_07] Codes 12 to 15 are high-side switch currents one to four.
// [RULE_08] Code 16 supply, 17 die temperature, 18 mirror pin; 19-24 reserved.
// [RULE_09] Codes 25 to 31 are the diagnostic channels, current mux last.
// [RULE_10] Hardware picks the reference from channel code and input config.
// [RULE_11] Ratiometric channels use the sensor supply pins as reference.
// [RULE_12] Absolute channels use the internal voltage reference.
// [RULE_13] The supply channel is attenuated by eight before conversion.
// [RULE_14] Current channels use the current reference and are unsigned.
// [RULE_15] Software selects signed or unsigned result representation.
// [RULE_16] Config holds justify, signed, halt mode, rate; bits 7:6 read zero.
// [RULE_17] Interrupt flags live in their own status register.
// [RULE_18] Channel select writes are ignored while a conversion runs.
// [RULE_19] Halt mode waits for a result read before the next sample.
// [RULE_20] Signed results span -512 to +511, unsigned 0 to 1023.
// [RULE_21] Flags clear by writing one; ready is masked with comparator on.
// [RULE_22] Configuration writes are blocked while the converter is not idle.
// [RULE_23] Cleared continuous-run: the running conversion ends, then idle.
package adc_ctrl_pkg;
    // Offsets are register indices; the byte address is four times each.
    localparam logic [7:0] IDX_FLAGS = 8'h0d;
    localparam logic [7:0] IDX_AINCFG = 8'h10;
    localparam logic [7:0] IDX_CONF = 8'h11;
    localparam logic [7:0] IDX_CTRL = 8'h12;
    localparam logic [7:0] IDX_RESULT = 8'h13;
    localparam logic [7:0] IDX_CMP = 8'h14;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'h7f;
    localparam logic [7:0] CONF_MASK = 8'h3f;
    localparam int CTRL_CONT_BIT = 6;
    localparam int CTRL_ONE_BIT = 5;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 5;
    localparam int CONF_JUST_BIT = 5;
    localparam int CONF_SIGN_BIT = 4;
    localparam int CONF_HALT_BIT = 3;
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 3;
    localparam int AIN_MD_LSB = 0;
    localparam int AIN_TM_LSB = 4;
    localparam int AIN_SN_BIT = 6;
    localparam int AIN_SP_BIT = 7;
    localparam int FLAG_RDY = 0;
    localparam int FLAG_CMP = 1;
    localparam int FLAG_N = 2;
    localparam int CMP_EN_BIT = 0;

    localparam logic [4:0] CH_AIN_LAST = 5'h03;
    localparam logic [4:0] CH_CUR_LAST = 5'h0f;
    localparam logic [4:0] CH_SUPPLY = 5'h10;
    localparam logic [4:0] CH_DIAG_RATIO_A = 5'h19;
    localparam logic [4:0] CH_DIAG_RATIO_B = 5'h1a;
    localparam logic [4:0] CH_CUR_DIAG = 5'h1f;

    localparam int RES_W = 10;
    localparam int RESULT_W = 16;
    localparam int JUST_PAD = 6;
    localparam logic [9:0] SIGN_FLIP = 10'h200;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        REF_SENSOR = 2'b00,
        REF_INTERNAL = 2'b01,
        REF_CURRENT = 2'b10
    } ref_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_HOLD = 2'b10
    } seq_state_t;
endpackage

// *** src/seq_if.sv ***
`timescale 1ns/1ps
interface seq_if;
    logic continuous_run;
    logic one_shot;
    logic halt_mode;
    logic result_unread;
    logic conv_done;
    logic conv_start;
    logic busy;
    logic finish;
    logic clear_one_shot;
    modport ctrl(
        output continuous_run, one_shot, halt_mode, result_unread, conv_done,
        input conv_start, busy, finish, clear_one_shot
    );
    modport seq(
        input continuous_run, one_shot, halt_mode, result_unread, conv_done,
        output conv_start, busy, finish, clear_one_shot
    );
endinterface

// *** src/adc_sequencer.sv ***
`timescale 1ns/1ps
module adc_sequencer
    import adc_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    seq_if.seq sq
);
    seq_state_t state;
    logic next_start;
    logic start_q;

    always_comb begin
        next_start = 1'b0;
        case (state)
            ST_IDLE: next_start = sq.continuous_run | sq.one_shot;
            ST_RUN: next_start = sq.conv_done & sq.continuous_run
                & ~sq.halt_mode; // [RULE_02]
            ST_HOLD: next_start = sq.continuous_run
                & ~sq.result_unread; // [RULE_19]
            default: next_start = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (sq.continuous_run || sq.one_shot) begin // [RULE_03]
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // A cleared run bit only takes effect at the end. [RULE_23]
                    if (sq.conv_done) begin
                        if (!sq.continuous_run) begin
                            state <= ST_IDLE;
                        end else if (sq.halt_mode) begin
                            state <= ST_HOLD; // [RULE_19]
                        end
                    end
                end
                ST_HOLD: begin
                    if (!sq.continuous_run) begin
                        state <= ST_IDLE;
                    end else if (!sq.result_unread) begin
                        state <= ST_RUN;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= next_start;
        end
    end

    assign sq.conv_start = start_q;
    assign sq.busy = (state != ST_IDLE);
    assign sq.finish = (state == ST_RUN) & sq.conv_done;
    // The one-shot is spent by any finished conversion that ends the run.
    assign sq.clear_one_shot = sq.finish & ~sq.continuous_run; // [RULE_03]

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence done_continuing;
        state == ST_RUN && sq.conv_done && sq.continuous_run && !sq.halt_mode;
    endsequence

    sequence done_stopping;
        state == ST_RUN && sq.conv_done && !sq.continuous_run;
    endsequence

    back_to_back_a: assert property ( // [RULE_02]
        done_continuing |=> state == ST_RUN && sq.conv_start)
        else $error("continuous run did not restart");
    one_shot_start_a: assert property ( // [RULE_03]
        state == ST_IDLE && sq.one_shot |=> sq.conv_start ##1 sq.busy)
        else $error("one-shot did not start a conversion");
    halt_wait_a: assert property ( // [RULE_19]
        state == ST_HOLD && sq.result_unread |=> !sq.conv_start)
        else $error("sample started before result was read");
    stop_idle_a: assert property ( // [RULE_23]
        done_stopping |=> state == ST_IDLE && !sq.conv_start)
        else $error("converter did not go idle after run cleared");
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
    mismatches++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module tb_top;
    import adc_ctrl_pkg::*;
    localparam logic [7:0] A_FLAGS = IDX_FLAGS << 2;
    localparam logic [7:0] A_AIN = IDX_AINCFG << 2;
    localparam logic [7:0] A_CONF = IDX_CONF << 2;
    localparam logic [7:0] A_CTRL = IDX_CTRL << 2;
    localparam logic [7:0] A_RES = IDX_RESULT << 2;
    localparam logic [7:0] A_CMP = IDX_CMP << 2;
    logic core_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, conv_done = 0, comparator_event = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, conv_start, adc_event;
    logic supply_attenuate, sensor_supply_switch, sensor_ground_switch;
    logic [1:0] bresp, rresp, ref_select, diode_current_enable, resp;
    logic [4:0] mux_channel, ch;
    logic [2:0] sample_rate_code;
    logic [7:0] ain;
    logic [9:0] conv_data = 0, next_raw = 0, cur_raw = 0;
    int mismatches = 0, check_count = 0, cycles = 0, starts = 0, cnt = 0;
    int base = 0;

    adc_conversion_control adc_conversion_control_i (.core_clk(core_clk),
        .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .conv_done(conv_done), .conv_data(conv_data),
        .comparator_event(comparator_event), .conv_start(conv_start),
        .mux_channel(mux_channel), .ref_select(ref_select),
        .supply_attenuate(supply_attenuate),
        .sample_rate_code(sample_rate_code),
        .sensor_supply_switch(sensor_supply_switch),
        .sensor_ground_switch(sensor_ground_switch),
        .diode_current_enable(diode_current_enable), .adc_event(adc_event));

    initial forever #25 core_clk = ~core_clk;

    // Converter stand-in: the data lines carry noise except with the done pulse.
    always @(posedge core_clk) begin
        conv_done <= (cnt == 1);
        conv_data <= (cnt == 1) ? cur_raw : 10'($urandom);
        if (conv_start) begin
            cnt <= 12;
            cur_raw <= next_raw;
            starts <= starts + 1;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    function automatic logic is_cur(logic [4:0] c);
        return (c >= 5'h04 && c <= 5'h0f) || c == 5'h1f;
    endfunction

    function automatic logic [1:0] exp_ref(logic [4:0] c, logic [7:0] a);
        if (c <= 5'h03)
            return (a[c] || (c >= 5'h02 && a[c+2])) ? REF_INTERNAL : REF_SENSOR;
        if (is_cur(c))
            return REF_CURRENT;
        if (c == 5'h19 || c == 5'h1a)
            return REF_SENSOR;
        return REF_INTERNAL;
    endfunction

    function automatic logic [15:0] exp_res(logic [9:0] r, logic [4:0] c,
                                            logic [7:0] f);
        logic s;
        logic [9:0] v;
        s = f[4] && !is_cur(c);
        v = s ? r ^ 10'h200 : r;
        if (!f[5])
            return {v, 6'h00};
        return s ? {{6{v[9]}}, v} : {6'h00, v};
    endfunction

    task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
                             output logic [1:0] r);
        logic aw, w, b;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        b = 0;
        while (!b) begin
            @(negedge core_clk);
            aw = awvalid & awready;
            w = wvalid & wready;
            b = bvalid;
            r = bresp;
            @(posedge core_clk);
            if (aw) awvalid <= 0;
            if (w) wvalid <= 0;
        end
        bready <= 0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        logic ar, v;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        v = 0;
        while (!v) begin
            @(negedge core_clk);
            ar = arvalid & arready;
            v = rvalid;
            d = rdata;
            r = rresp;
            @(posedge core_clk);
            if (ar) arvalid <= 0;
        end
        rready <= 0;
    endtask

    // Field writes land while the converter is busy, before its done pulse.
    task automatic run_one(input logic [4:0] c, input logic [7:0] f,
                           input logic ev);
        axi_write(A_CONF, f, resp);
        axi_write(A_CTRL, {3'h1, c}, resp);
        while (conv_start !== 1'h1) @(negedge core_clk);
        axi_write(A_CTRL, {3'h1, ~c}, resp);
        axi_write(A_CONF, ~f, resp);
        repeat (20) @(posedge core_clk);
        axi_read(A_CTRL, rd, resp);
        `CHK("ctrl", {27'h0, c}, rd)
        axi_read(A_CONF, rd, resp);
        `CHK("conf", {24'h0, f & 8'h3f}, rd)
        `CHK("rate", f[2:0], sample_rate_code)
        axi_read(A_RES, rd, resp);
        `CHK("result", {16'h0, exp_res(next_raw, c, f)}, rd)
        `CHK("event", ev, adc_event)
        axi_read(A_FLAGS, rd, resp);
        `CHK("flags", 32'h1, rd)
        axi_write(A_FLAGS, 8'h01, resp);
        axi_read(A_FLAGS, rd, resp);
        `CHK("flags clr", 32'h0, rd)
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h0600b384));
        repeat (10) @(posedge core_clk);
        rst_n <= 1;
        for (int i = 0; i < 6; i++) begin
            axi_read(i == 0 ? A_FLAGS : 8'(A_AIN + 4 * (i - 1)), rd, resp);
            `CHK("reset", 32'h0, rd)
        end
        axi_write(A_CONF, 8'hff, resp);
        axi_read(A_CONF, rd, resp);
        `CHK("conf mask", 32'h3f, rd)
        axi_write(A_CONF, 8'h00, resp);
        axi_write(A_CTRL, 8'h9f, resp);
        axi_read(A_CTRL, rd, resp);
        `CHK("ctrl bit7", 32'h1f, rd)
        axi_write(8'hfc, 8'h01, resp);
        `CHK("unmapped w", RESP_SLVERR, resp)
        axi_read(8'hfc, rd, resp);
        `CHK("unmapped r", RESP_SLVERR, resp)
        $display("test registers done");
        for (int c = 0; c < 32; c++) begin
            ain = 8'($urandom);
            axi_write(A_AIN, ain, resp);
            axi_write(A_CTRL, 8'(c), resp);
            repeat (3) @(posedge core_clk);
            `CHK("mux", 5'(c), mux_channel)
            `CHK("ref", exp_ref(5'(c), ain), ref_select)
            `CHK("atten", c == 16, supply_attenuate)
            `CHK("pins", ain[7:4], {sensor_supply_switch,
                sensor_ground_switch, diode_current_enable})
        end
        $display("test channels done");
        for (int i = 0; i < 8; i++) begin
            next_raw = i == 0 ? 10'h000 : i == 1 ? 10'h3ff : 10'($urandom);
            run_one(5'($urandom), 8'($urandom) & 8'h37, 1'h1);
        end
        $display("test one shot done");
        axi_write(A_CMP, 8'h01, resp);
        comparator_event <= 1;
        @(posedge core_clk);
        comparator_event <= 0;
        repeat (2) @(posedge core_clk);
        `CHK("cmp event", 1'h1, adc_event)
        axi_write(A_FLAGS, 8'h02, resp);
        `CHK("cmp clr", 1'h0, adc_event)
        run_one(5'($urandom), 8'h20, 1'h0);
        axi_write(A_CMP, 8'h00, resp);
        $display("test comparator done");
        ch = 5'($urandom);
        axi_write(A_CTRL, {3'h3, ch}, resp);
        @(negedge core_clk) base = starts;
        repeat (80) @(posedge core_clk);
        `CHK("continuous", 1'h1, starts - base >= 4)
        axi_write(A_CTRL, 8'h00, resp);
        @(negedge core_clk) base = starts;
        repeat (40) @(posedge core_clk);
        `CHK("stop", 0, starts - base)
        axi_read(A_CTRL, rd, resp);
        `CHK("ctrl idle", {27'h0, ch}, rd)
        $display("test continuous done");
        axi_write(A_CONF, 8'h08, resp);
        @(negedge core_clk) base = starts;
        axi_write(A_CTRL, 8'h40, resp);
        repeat (60) @(posedge core_clk);
        `CHK("halt", 1, starts - base)
        axi_read(A_RES, rd, resp);
        repeat (30) @(posedge core_clk);
        `CHK("resume", 2, starts - base)
        axi_write(A_CTRL, 8'h00, resp);
        axi_read(A_RES, rd, resp);
        repeat (30) @(posedge core_clk);
        $display("test halt done");
        report_and_stop();
    end
endmodule
